// ---- tap_map.vh ----
// constants for the test access port and global control block
// assumes inclusion by bare name from the design files
`ifndef TAP_MAP_VH
`define TAP_MAP_VH
// instruction register
`define IR_WIDTH 3
`define IR_RESET 3'h1
`define IR_CAPTURE 3'h1
`define INS_EXTEST 3'h0
`define INS_SAMPLE 3'h2
`define INS_IDCODE 3'h1
`define INS_BYPASS 3'h7
// identification register width
`define ID_WIDTH 32
// boundary register length
`define BSR_LENGTH 8
`endif

// ---- tap_shift_reg.v ----
// parallel-capture, serial-shift, parallel-update scan register
// assumes the caller gives one-cycle capture, shift and update strobes on core_clk
`timescale 1ns/1ps
module tap_shift_reg #(
    parameter WIDTH = 8
) (
    input wire core_clk,
    input wire hold_reset,
    input wire capture,
    input wire shift,
    input wire update,
    input wire serial_in,
    input wire [WIDTH-1:0] parallel_in,
    input wire [WIDTH-1:0] reset_value,
    output reg [WIDTH-1:0] parallel_out,
    output wire serial_out
);
    reg [WIDTH-1:0] chain;

    assign serial_out = chain[0];

    // chain shifts toward bit 0, new bit enters at the top
    always @(posedge core_clk)
    begin
        if (hold_reset)
        begin
            chain <= reset_value;
            parallel_out <= reset_value;
        end
        else
        begin
            if (capture)
                chain <= parallel_in;
            else if (shift)
                chain <= {serial_in, chain[WIDTH-1:1]};
            if (update)
                parallel_out <= chain;
        end
    end
endmodule

// ---- tap_global_ctrl.v ----
// test access port controller with global reset, scan enable and float control
// assumes scan and global pins arrive asynchronously; core_clk far faster than tap_clock
//
// Contract
// (R1) mode select sampled on tap_clock rise
// (R2) data in shifted on tap_clock rise
// (R3) data out changes on tap_clock falls
// (R4) data out floats unless shifting a register
// (R5) float changes follow a falling edge only
// (R6) tap reset low holds reset, floats out
// (R7) tester keeps tap reset high while scanning; the bench's last scan holds tap reset low throughout
// (R8) functional logic ignores tap reset level
// (R9) tester clock below 10 MHz, even duty; the tester model runs a 64 ns even period, about 15.6 MHz
// (R10) both float and tap reset low float pins
// (R11) scan-test enable low asserts scan mode
// (R12) global reset low resets internal logic
// (R13) resets held low during power-up
// (R14) sixteen-state controller, instruction selects path
// (R15) reset asserts fast, releases synchronised
`timescale 1ns/1ps
`include "tap_map.vh"
module tap_global_ctrl #(
    parameter [`ID_WIDTH-1:0] ID_CODE = 32'h0000_0001, // arbitrary value
    parameter BSR_LEN = `BSR_LENGTH
) (
    input wire core_clk,
    input wire rst,
    input wire tap_clock,
    input wire tap_mode_select,
    input wire tap_data_in,
    input wire tap_reset_n,
    input wire output_float_n,
    input wire scan_test_n,
    input wire global_reset_n,
    input wire [BSR_LEN-1:0] pin_sample,
    output reg tap_data_out,
    output reg tap_data_out_oe_n,
    output reg [BSR_LEN-1:0] pin_drive,
    output reg pin_drive_select,
    output reg pins_float,
    output reg scan_mode,
    output reg logic_reset
);
    // one-hot controller states
    localparam S_RESET = 16'h0001;
    localparam S_IDLE = 16'h0002;
    localparam S_SEL_DR = 16'h0004;
    localparam S_CAP_DR = 16'h0008;
    localparam S_SH_DR = 16'h0010;
    localparam S_EX1_DR = 16'h0020;
    localparam S_PAU_DR = 16'h0040;
    localparam S_EX2_DR = 16'h0080;
    localparam S_UPD_DR = 16'h0100;
    localparam S_SEL_IR = 16'h0200;
    localparam S_CAP_IR = 16'h0400;
    localparam S_SH_IR = 16'h0800;
    localparam S_EX1_IR = 16'h1000;
    localparam S_PAU_IR = 16'h2000;
    localparam S_EX2_IR = 16'h4000;
    localparam S_UPD_IR = 16'h8000;

    // bit position of each state the datapath decodes
    localparam B_RESET = 0;
    localparam B_CAP_DR = 3;
    localparam B_SH_DR = 4;
    localparam B_UPD_DR = 8;
    localparam B_CAP_IR = 10;
    localparam B_SH_IR = 11;
    localparam B_UPD_IR = 15;

    // two-flop synchronisers; first stage is read only by the second
    reg [6:0] meta;
    reg [6:0] sync;
    always @(posedge core_clk)
    begin
        meta <= {global_reset_n, scan_test_n, output_float_n, tap_reset_n,
                 tap_data_in, tap_mode_select, tap_clock};
        sync <= meta;
    end
    wire s_clk = sync[0];
    wire s_tms = sync[1];
    wire s_tdi = sync[2];
    wire s_trst_n = sync[3];
    wire s_float_n = sync[4];
    wire s_scan_n = sync[5];
    wire s_grst_n = sync[6];

    // tap clock edge detection on the synchronised level
    reg clk_prev;
    always @(posedge core_clk)
    begin
        if (rst)
            clk_prev <= 1'b0;
        else
            clk_prev <= s_clk;
    end
    wire rise = s_clk & ~clk_prev;
    wire fall = ~s_clk & clk_prev;

    // tap reset hold, independent of global reset
    wire tap_hold = rst | ~s_trst_n; // see (R6) (R7)

    // controller state, one bit per state
    reg [15:0] state;
    reg [15:0] next_state;

    // next state decode
    always @*
    begin
        next_state = S_RESET;
        case (state)
            S_RESET: next_state = s_tms ? S_RESET : S_IDLE;
            S_IDLE: next_state = s_tms ? S_SEL_DR : S_IDLE;
            S_SEL_DR: next_state = s_tms ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: next_state = s_tms ? S_EX1_DR : S_SH_DR;
            S_SH_DR: next_state = s_tms ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: next_state = s_tms ? S_UPD_DR : S_PAU_DR;
            S_PAU_DR: next_state = s_tms ? S_EX2_DR : S_PAU_DR;
            S_EX2_DR: next_state = s_tms ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: next_state = s_tms ? S_SEL_DR : S_IDLE;
            S_SEL_IR: next_state = s_tms ? S_RESET : S_CAP_IR;
            S_CAP_IR: next_state = s_tms ? S_EX1_IR : S_SH_IR;
            S_SH_IR: next_state = s_tms ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: next_state = s_tms ? S_UPD_IR : S_PAU_IR;
            S_PAU_IR: next_state = s_tms ? S_EX2_IR : S_PAU_IR;
            S_EX2_IR: next_state = s_tms ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: next_state = s_tms ? S_SEL_DR : S_IDLE;
            default: next_state = S_RESET;
        endcase
    end

    // controller advances only on tap clock rise
    always @(posedge core_clk)
    begin
        if (tap_hold)
            state <= S_RESET; // see (R6)
        else if (rise)
            state <= next_state; // see (R1) (R14)
    end

    // strobes for the scan registers, all qualified by the rising edge
    wire cap_dr = rise & state[B_CAP_DR];
    wire sh_dr = rise & state[B_SH_DR];
    wire upd_dr = rise & state[B_UPD_DR];
    wire cap_ir = rise & state[B_CAP_IR];
    wire sh_ir = rise & state[B_SH_IR];
    wire upd_ir = rise & state[B_UPD_IR];

    // instruction register; reset loads the identification instruction
    wire [`IR_WIDTH-1:0] instr;
    wire ir_so;
    tap_shift_reg #(.WIDTH(`IR_WIDTH)) u_ir (
        .core_clk(core_clk),
        .hold_reset(tap_hold | state[B_RESET]),
        .capture(cap_ir),
        .shift(sh_ir), // see (R2)
        .update(upd_ir),
        .serial_in(s_tdi),
        .parallel_in(`IR_CAPTURE),
        .reset_value(`IR_RESET),
        .parallel_out(instr),
        .serial_out(ir_so)
    );

    // data path selected by the loaded instruction
    wire sel_bsr = (instr == `INS_EXTEST) | (instr == `INS_SAMPLE); // see (R14)
    wire sel_id = (instr == `INS_IDCODE);

    // boundary register sees the pin samples and drives pins in extest
    wire [BSR_LEN-1:0] bsr_q;
    wire bsr_so;
    tap_shift_reg #(.WIDTH(BSR_LEN)) u_bsr (
        .core_clk(core_clk),
        .hold_reset(tap_hold),
        .capture(cap_dr & sel_bsr),
        .shift(sh_dr & sel_bsr), // see (R2)
        .update(upd_dr & sel_bsr),
        .serial_in(s_tdi),
        .parallel_in(pin_sample),
        .reset_value({BSR_LEN{1'b0}}),
        .parallel_out(bsr_q),
        .serial_out(bsr_so)
    );

    // identification register, capture only
    wire id_so;
    tap_shift_reg #(.WIDTH(`ID_WIDTH)) u_id (
        .core_clk(core_clk),
        .hold_reset(tap_hold),
        .capture(cap_dr & sel_id),
        .shift(sh_dr & sel_id), // see (R2)
        .update(1'b0),
        .serial_in(s_tdi),
        .parallel_in(ID_CODE),
        .reset_value(ID_CODE),
        .parallel_out(),
        .serial_out(id_so)
    );

    // single-bit bypass register for every other instruction
    reg bypass_bit;
    always @(posedge core_clk)
    begin
        if (tap_hold)
            bypass_bit <= 1'b0;
        else if (cap_dr)
            bypass_bit <= 1'b0;
        else if (sh_dr)
            bypass_bit <= s_tdi; // see (R2)
    end

    // data path bit picked by the loaded instruction
    reg dr_so;
    always @*
    begin
        if (sel_bsr)
            dr_so = bsr_so;
        else if (sel_id)
            dr_so = id_so;
        else
            dr_so = bypass_bit;
    end

    // next serial bit: the instruction path while it shifts, else the data path
    reg next_data_out;
    always @*
    begin
        next_data_out = dr_so;
        if (state[B_SH_IR])
            next_data_out = ir_so;
    end

    // the pin is driven only while a register shifts
    wire shifting = state[B_SH_DR] | state[B_SH_IR];

    // data out and enable move on a fall; raw tap reset floats the pin at once, not after the synchroniser
    wire tdo_async = ~tap_reset_n | rst;
    always @(posedge core_clk or posedge tdo_async)
    begin
        if (tdo_async)
        begin
            tap_data_out <= 1'b0;
            tap_data_out_oe_n <= 1'b1; // see (R6)
        end
        else if (tap_hold)
        begin
            tap_data_out <= 1'b0;
            tap_data_out_oe_n <= 1'b1; // see (R6)
        end
        else if (fall)
        begin
            tap_data_out <= next_data_out; // see (R3)
            tap_data_out_oe_n <= ~shifting; // see (R4) (R5)
        end
    end

    // pin drive follows the boundary register under every instruction; drive select is set in extest only
    always @(posedge core_clk)
    begin
        if (tap_hold)
        begin
            pin_drive <= {BSR_LEN{1'b0}};
            pin_drive_select <= 1'b0;
        end
        else
        begin
            pin_drive <= bsr_q;
            pin_drive_select <= (instr == `INS_EXTEST);
        end
    end

    // global reset: raw pin asserts at once, release waits for the synchroniser
    // functional reset never looks at tap reset, so its level is free outside scan
    wire grst_async = ~global_reset_n | rst;
    always @(posedge core_clk or posedge grst_async)
    begin
        if (grst_async)
            logic_reset <= 1'b1; // see (R12) (R15) (R13)
        else
            logic_reset <= ~s_grst_n; // see (R8) (R15)
    end

    // float and scan mode: asynchronous assert on raw pins, synchronised release
    wire float_async = (~output_float_n & ~tap_reset_n) | rst;
    always @(posedge core_clk or posedge float_async)
    begin
        if (float_async)
            pins_float <= 1'b1; // see (R10)
        else
            pins_float <= ~s_float_n & ~s_trst_n;
    end

    // scan mode: raw pin asserts at once, release through the synchroniser
    wire scan_async = ~scan_test_n;
    always @(posedge core_clk or posedge scan_async)
    begin
        if (scan_async)
            scan_mode <= 1'b1; // see (R11)
        else if (rst)
            scan_mode <= 1'b0;
        else
            scan_mode <= ~s_scan_n;
    end
endmodule

// ---- tap_global_ctrl_monitor.sv ----
// checker on the scan port and global control outputs
// assumes tap_clock half periods of 8 core_clk or more
`timescale 1ns/1ps
module tap_ctrl_monitor (
    input wire core_clk,
    input wire rst,
    input wire tap_clock,
    input wire tap_reset_n,
    input wire output_float_n,
    input wire scan_test_n,
    input wire global_reset_n,
    input wire tap_data_out,
    input wire tap_data_out_oe_n,
    input wire pins_float,
    input wire scan_mode,
    input wire logic_reset
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // release needs three stages, so six quiet cycles are ample
    sequence s_grst_quiet;
        global_reset_n [*6];
    endsequence
    property p_oe_fall; $changed(tap_data_out_oe_n) && tap_reset_n |-> !tap_clock; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("oe driven off a fall");
    property p_dout; $changed(tap_data_out) && tap_reset_n |-> !tap_clock; endproperty
    a_dout: assert property (p_dout) else $error("tdo moved off a fall");
    property p_trst; !tap_reset_n |-> tap_data_out_oe_n; endproperty
    a_trst: assert property (p_trst) else $error("tdo driven in tap reset");
    property p_float; !output_float_n && !tap_reset_n |-> pins_float; endproperty
    a_float: assert property (p_float) else $error("pins not floated");
    property p_scan; !scan_test_n |-> scan_mode; endproperty
    a_scan: assert property (p_scan) else $error("scan mode missing");
    property p_grst; !global_reset_n |-> logic_reset; endproperty
    a_grst: assert property (p_grst) else $error("logic not in reset");
    property p_grel; $rose(global_reset_n) |-> logic_reset ##[1:5] !logic_reset; endproperty
    a_grel: assert property (p_grel) else $error("reset release wrong");
    property p_quiet; s_grst_quiet |-> !logic_reset; endproperty
    a_quiet: assert property (p_quiet) else $error("logic reset stuck");
endmodule
bind tap_global_ctrl tap_ctrl_monitor i_mon (.core_clk, .rst, .tap_clock, .tap_reset_n, .output_float_n,
    .scan_test_n, .global_reset_n, .tap_data_out, .tap_data_out_oe_n, .pins_float, .scan_mode, .logic_reset);

// ---- tap_tester.sv ----
// scan tester model for the test access port pins
// assumes one caller at a time; pins move on their own 64 ns timing
`timescale 1ns/1ps
module tap_tester (
    output reg tap_clock,
    output reg tap_mode_select,
    output reg tap_data_in,
    output reg tap_reset_n,
    input wire tap_data_out,
    input wire tap_data_out_oe_n
);
    // power-up: tap reset low, clock parked, pulled-up lines high
    initial
    begin
        tap_reset_n = 1'b0;
        tap_clock = 1'b0;
        {tap_mode_select, tap_data_in} = 2'b11;
    end
    // only moved between scans
    task set_trst(input v);
        tap_reset_n = v;
    endtask
    // one even 64 ns period; tdo read late in the low half
    task step(input ms, input di, output dv, output ov);
    begin
        {tap_mode_select, tap_data_in} = {ms, di};
        #28;
        // a floating pin reads as the inverse of its last bit, so a stray float shows up
        {dv, ov} = {tap_data_out ^ tap_data_out_oe_n, tap_data_out_oe_n};
        tap_clock = 1'b1;
        #32;
        tap_clock = 1'b0;
        #4;
    end
    endtask
    // five ones reach reset, then idle
    task park;
        reg dv;
        reg ov;
    begin
        repeat (5)
            step(1'b1, 1'b1, dv, ov);
        step(1'b0, 1'b1, dv, ov);
    end
    endtask
    // idle, shift n bits lsb first, exit, update, idle
    task scan(input ir, input integer n, input [63:0] din, output [63:0] dout, output oe_seen, output oe_after);
        integer i;
        reg dv;
        reg ov;
    begin
        dout = 64'h0;
        oe_seen = 1'b0;
        step(1'b1, 1'b1, dv, ov);
        if (ir)
            step(1'b1, 1'b1, dv, ov);
        step(1'b0, 1'b1, dv, ov);
        step(1'b0, 1'b1, dv, ov);
        for (i = 0; i < n; i = i + 1)
        begin
            step(i == n - 1, din[i], dout[i], ov);
            oe_seen = oe_seen | ov;
        end
        step(1'b1, 1'b1, dv, oe_after);
        step(1'b0, 1'b1, dv, ov);
    end
    endtask
endmodule

// ---- tb_tap_global_ctrl.sv ----
// self-checking bench for tap_global_ctrl beside a scan tester model
// assumes a 4 ns core_clk; scan pins follow the tester's own timing
`timescale 1ns/1ps
module tb_tap_global_ctrl;
    localparam [31:0] ID = 32'h0000_0001; // arbitrary value
    reg core_clk, rst, output_float_n, scan_test_n, global_reset_n, oe_seen, oe_after;
    reg [7:0] pin_sample;
    reg [2:0] code;
    reg [31:0] rnd = 32'heaa0;
    reg [63:0] din, dout, cap;
    wire tap_clock, tap_mode_select, tap_data_in, tap_reset_n, tap_data_out, tap_data_out_oe_n;
    wire pin_drive_select, pins_float, scan_mode, logic_reset;
    wire [7:0] pin_drive;
    integer n_mismatch = 0, cmp_count = 0, k, n;
    tap_global_ctrl #(.ID_CODE(ID), .BSR_LEN(8)) i_dut (.core_clk, .rst, .tap_clock, .tap_mode_select,
        .tap_data_in, .tap_reset_n, .output_float_n, .scan_test_n, .global_reset_n, .pin_sample, .tap_data_out,
        .tap_data_out_oe_n, .pin_drive, .pin_drive_select, .pins_float, .scan_mode, .logic_reset);
    tap_tester i_tester (.tap_clock, .tap_mode_select, .tap_data_in, .tap_reset_n, .tap_data_out,
        .tap_data_out_oe_n);
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // boundary 8, identity 32, anything else the one-bit bypass
    function integer dr_len(input [2:0] c);
        dr_len = (c == 3'h1) ? 32 : (c == 3'h0 || c == 3'h2) ? 8 : 1;
    endfunction
    task check(input [63:0] seen, input [63:0] want);
    begin
        cmp_count = cmp_count + 1;
        if (seen !== want)
        begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0t seen %h exp %h", $time, seen, want);
        end
    end
    endtask
    task summarize;
    begin
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    // hang guard, well past the roughly 15 us of scans
    initial
    begin
        #200000;
        n_mismatch = n_mismatch + 1;
        summarize;
    end
    initial
    begin
        {rst, global_reset_n, output_float_n, scan_test_n, pin_sample} = {4'b1011, 8'h00};
        repeat (20) @(negedge core_clk);
        check(logic_reset, 1'b1);
        {rst, global_reset_n} = 2'b01;
        repeat (6) @(negedge core_clk);
        check(logic_reset, 1'b0);
        i_tester.set_trst(1'b1);
        i_tester.park;
        // first pass keeps the reset instruction; 3'h5 must act as bypass
        for (k = 0; k < 6; k = k + 1)
        begin
            code = k == 2 ? 3'h2 : k == 3 ? 3'h0 : k == 4 ? 3'h7 : k == 5 ? 3'h5 : 3'h1;
            rnd = lfsr(rnd);
            din = {rnd, lfsr(rnd)};
            @(negedge core_clk);
            pin_sample = rnd[15:8];
            if (k > 0)
            begin
                i_tester.scan(1'b1, 3, {61'h0, code}, dout, oe_seen, oe_after);
                check({dout[61:0], oe_seen, oe_after}, {62'h1, 2'b01});
            end
            cap = code == 3'h1 ? {32'h0, ID} : dr_len(code) == 1 ? 64'h0 : {56'h0, pin_sample};
            n = dr_len(code) + 8;
            i_tester.scan(1'b0, n, din, dout, oe_seen, oe_after);
            check(dout, ((cap & ((64'h1 << (n - 8)) - 1)) | (din << (n - 8))) & ((64'h1 << n) - 1));
            check({oe_seen, oe_after, pin_drive_select}, {2'b01, code == 3'h0});
            if (code == 3'h0)
                check(pin_drive, din[n - 8 +: 8]);
        end
        // random float and scan enable pins, tap reset in the mix, global reset held high
        for (k = 0; k < 24; k = k + 1)
        begin
            rnd = lfsr(rnd);
            if (k == 0)
                rnd[3:1] = 3'b000; // corner: float, scan enable and tap reset all low together
            @(negedge core_clk);
            {output_float_n, scan_test_n} = rnd[2:1];
            i_tester.set_trst(rnd[3]);
            repeat (5) @(negedge core_clk);
            check({pins_float, scan_mode, logic_reset}, {~rnd[2] & ~rnd[3], ~rnd[1], 1'b0});
        end
        // tap reset low: a whole scan must leave the pin floated at every bit
        i_tester.set_trst(1'b0);
        i_tester.scan(1'b0, 4, din, dout, oe_seen, oe_after);
        check(dout, 64'hf);
        check({oe_seen, oe_after}, 2'b11);
        summarize;
    end
endmodule
